/* File: rtl/monitor_adc_pkg.sv */
/*
 * Shared constants and types for the monitoring converter and host alert
 * controller. Assumes one 25 MHz system clock.
 */
package monitor_adc_pkg;

   // Register offsets on the register port.
   localparam logic [7:0] STAT_ADDR = 8'h10;
   localparam logic [7:0] FLAG_ADDR = 8'h11;
   localparam logic [7:0] MASK_ADDR = 8'h12;
   localparam logic [7:0] CTRL_ADDR = 8'h15;
   localparam logic [7:0] DIS_ADDR = 8'h16;
   localparam logic [7:0] RB_FIRST_ADDR = 8'h17;
   localparam logic [7:0] RB_LAST_ADDR = 8'h24;
   localparam logic [7:0] UNMAPPED_READ = 8'hff;

   // Reset values.
   localparam logic [7:0] CTRL_RESET = 8'h30;
   localparam logic [7:0] DIS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;

   // Conversion control fields.
   localparam int EN_BIT = 7;
   localparam int RATE_BIT = 6;
   localparam int SAMPLE_LSB = 4;

   // Channels: disable bits 7..1 map to channels 6..0.
   localparam int NUM_CH = 7;
   localparam int DIS_CH_LSB = 1;

   // Alert sources (bit positions in status, flag and mask).
   localparam int SRC_DONE = 0;
   localparam int SRC_PGOOD = 1;
   localparam int SRC_OVP = 2;
   localparam int SRC_INPUT = 3;
   localparam int SRC_REG = 4;
   localparam int SRC_WDOG = 5;
   localparam int SRC_CHRG = 6;
   localparam int SRC_FAULT = 7;

   // Timing.
   localparam int CLK_PERIOD_NS = 40;
   localparam int ALERT_TIME_NS = 256000;
   localparam int ALERT_CYCLES = ALERT_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_BASE_TIME_NS = 1000000;
   localparam int CONV_BASE_CYCLES = CONV_BASE_TIME_NS / CLK_PERIOD_NS;
   localparam int ALERT_CNT_W = 13;
   localparam int CONV_CNT_W = 20;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_PAUSE = 2'b10
   } convState_type;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } regReq_type;

   typedef struct packed {
      logic vbusAboveUvlo;
      logic vbusBelowOv;
      logic poorSourcePassed;
      logic detectDone;
      logic batAboveUvlo;
      logic modeChangeBusy;
      logic inputSourceChange;
      logic regulationEntry;
      logic watchdogExpired;
      logic chargeStatusChange;
      logic faultEvent;
   } chargerPins_type;

endpackage

/* File: rtl/monitor_adc_and_host_alert_ctrl.sv */
/*
 * Sequencer for the monitoring converter plus host alert, flag and
 * power-good logic. Assumes the converter macro presents convData on clk
 * at the end of each conversion time, and that charger pins are async.
 */
`timescale 1ns/1ns
`default_nettype none

module monitor_adc_and_host_alert_ctrl #(
   parameter int ALERT_CYCLES = monitor_adc_pkg::ALERT_CYCLES,
   parameter int CONV_BASE_CYCLES = monitor_adc_pkg::CONV_BASE_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire monitor_adc_pkg::regReq_type regReq,
   output logic [7:0] regRdData,
   input wire monitor_adc_pkg::chargerPins_type pins,
   input wire logic [15:0] convData,
   output logic convStart,
   output logic [2:0] convChannel,
   output logic alertPin_n,
   output logic powerGoodPin_n,
   output logic switchingEnable
);

   localparam int N = monitor_adc_pkg::NUM_CH;
   localparam int AW = monitor_adc_pkg::ALERT_CNT_W;
   localparam int CW = monitor_adc_pkg::CONV_CNT_W;

   // Three-stage pin synchroniser with an agreement filter.
   monitor_adc_pkg::chargerPins_type pinS1_q, pinS2_q, pinS3_q;
   monitor_adc_pkg::chargerPins_type pinF_q, pinF_d;

   logic [7:0] ctrl_q, ctrl_d, dis_q, dis_d, mask_q, mask_d;
   logic [7:0] flag_q, flag_d, statPrev_q, status, events;
   logic [7:0] rdData_q, rdData_d;
   logic [AW-1:0] alertCnt_q, alertCnt_d;
   logic alertActive_q, startup_q, doneStat_q, doneStat_d;
   logic goodPin_q, swEn_q;
   monitor_adc_pkg::convState_type state_q, state_d;
   logic [2:0] ch_q, ch_d;
   logic [N-1:0] cycleMask_q, cycleMask_d, liveMask;
   logic [CW-1:0] convCnt_q, convCnt_d, convCycles;
   logic convStart_q, convStart_d;
   logic [15:0] rb_q [N];
   logic [15:0] rb_d [N];
   logic powerGood, supplyOk, modeHold, oneShot, readFlag;
   logic [3:0] nextAfter, firstLive;
   logic [7:0] rbIdx;

   // Returns {found, index} of the first set bit at or above start.
   function automatic logic [3:0] firstFrom(input logic [N-1:0] m,
                                            input logic [3:0] start);
      logic [3:0] r;
      r = 4'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (m[i] && (4'(i) >= start)) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   assign powerGood = pinF_q.vbusAboveUvlo & pinF_q.vbusBelowOv &
                      pinF_q.poorSourcePassed & pinF_q.detectDone;
   assign supplyOk = pinF_q.vbusAboveUvlo | pinF_q.batAboveUvlo;
   assign modeHold = pinF_q.modeChangeBusy |
                     (pinF_q.vbusAboveUvlo & ~pinF_q.detectDone);
   assign oneShot = ~ctrl_q[monitor_adc_pkg::RATE_BIT];
   assign liveMask = ~dis_q[monitor_adc_pkg::DIS_CH_LSB +: N];
   assign readFlag = regReq.rdEn && (regReq.addr == monitor_adc_pkg::FLAG_ADDR);
   assign nextAfter = firstFrom(cycleMask_q, {1'b0, ch_q} + 4'h1);
   assign firstLive = firstFrom(liveMask, 4'h0);
   assign rbIdx = regReq.addr - monitor_adc_pkg::RB_FIRST_ADDR;

   // Live status of each alert source.
   always_comb begin
      status = 8'h00;
      status[monitor_adc_pkg::SRC_DONE] = doneStat_q;
      status[monitor_adc_pkg::SRC_PGOOD] = powerGood;
      // Over-voltage counts only with an input present, so that a bare
      // supply after reset raises no false event.
      status[monitor_adc_pkg::SRC_OVP] = pinF_q.vbusAboveUvlo &
                                         ~pinF_q.vbusBelowOv;
      status[monitor_adc_pkg::SRC_INPUT] = pinF_q.inputSourceChange;
      status[monitor_adc_pkg::SRC_REG] = pinF_q.regulationEntry;
      status[monitor_adc_pkg::SRC_WDOG] = pinF_q.watchdogExpired;
      status[monitor_adc_pkg::SRC_CHRG] = pinF_q.chargeStatusChange;
      status[monitor_adc_pkg::SRC_FAULT] = pinF_q.faultEvent;
   end

   // Conversion time per channel from the sample-speed field.
   always_comb begin
      case (ctrl_q[monitor_adc_pkg::SAMPLE_LSB +: 2])
         2'b00: convCycles = CW'(CONV_BASE_CYCLES * 8);
         2'b01: convCycles = CW'(CONV_BASE_CYCLES * 4);
         2'b10: convCycles = CW'(CONV_BASE_CYCLES * 2);
         default: convCycles = CW'(CONV_BASE_CYCLES);
      endcase
   end

   always_comb begin
      pinF_d = (pinS3_q & ~(pinS2_q ^ pinS3_q)) |
               (pinF_q & (pinS2_q ^ pinS3_q));
   end

   // Alert sources, flags and the timed alert pulse.
   always_comb begin
      events = status & ~statPrev_q;
      events[monitor_adc_pkg::SRC_PGOOD] = powerGood ^
         statPrev_q[monitor_adc_pkg::SRC_PGOOD];
      events[monitor_adc_pkg::SRC_WDOG] =
         events[monitor_adc_pkg::SRC_WDOG] | startup_q;
      flag_d = (readFlag ? 8'h00 : flag_q) | events;
      if (|(events & ~mask_q)) begin
         alertCnt_d = AW'(ALERT_CYCLES);
      end else if (alertCnt_q != '0) begin
         alertCnt_d = alertCnt_q - AW'(1);
      end else begin
         alertCnt_d = alertCnt_q;
      end
   end

   // Register writes, reads and the conversion sequencer.
   always_comb begin
      ctrl_d = ctrl_q;
      dis_d = dis_q;
      mask_d = mask_q;
      state_d = state_q;
      ch_d = ch_q;
      cycleMask_d = cycleMask_q;
      convCnt_d = convCnt_q;
      convStart_d = 1'b0;
      rb_d = rb_q;
      doneStat_d = oneShot ? doneStat_q : 1'b0;
      case (state_q)
         monitor_adc_pkg::ST_IDLE: begin
            if (ctrl_q[monitor_adc_pkg::EN_BIT]) begin
               if (!supplyOk) begin
                  ctrl_d[monitor_adc_pkg::EN_BIT] = 1'b0;
               end else if (liveMask == '0) begin
                  if (oneShot) begin
                     ctrl_d[monitor_adc_pkg::EN_BIT] = 1'b0;
                  end
               end else if (!modeHold) begin
                  // Armed start, also after all-disabled in continuous.
                  cycleMask_d = liveMask;
                  ch_d = firstLive[2:0];
                  convCnt_d = convCycles;
                  convStart_d = 1'b1;
                  doneStat_d = 1'b0;
                  state_d = monitor_adc_pkg::ST_CONVERT;
               end
            end
         end
         monitor_adc_pkg::ST_CONVERT: begin
            // Fault inputs are deliberately not consulted here.
            if (!ctrl_q[monitor_adc_pkg::EN_BIT]) begin
               state_d = monitor_adc_pkg::ST_IDLE;
            end else if (modeHold) begin
               state_d = monitor_adc_pkg::ST_PAUSE;
            end else if (convCnt_q != CW'(1)) begin
               convCnt_d = convCnt_q - CW'(1);
            end else begin
               rb_d[ch_q] = convData;
               if (liveMask == '0) begin
                  state_d = monitor_adc_pkg::ST_IDLE;
                  if (oneShot) begin
                     ctrl_d[monitor_adc_pkg::EN_BIT] = 1'b0;
                  end
               end else if (nextAfter[3]) begin
                  ch_d = nextAfter[2:0];
                  convCnt_d = convCycles;
                  convStart_d = 1'b1;
               end else if (oneShot) begin
                  ctrl_d[monitor_adc_pkg::EN_BIT] = 1'b0;
                  doneStat_d = 1'b1;
                  state_d = monitor_adc_pkg::ST_IDLE;
               end else begin
                  cycleMask_d = liveMask;
                  ch_d = firstLive[2:0];
                  convCnt_d = convCycles;
                  convStart_d = 1'b1;
               end
            end
         end
         monitor_adc_pkg::ST_PAUSE: begin
            if (!ctrl_q[monitor_adc_pkg::EN_BIT]) begin
               state_d = monitor_adc_pkg::ST_IDLE;
            end else if (!modeHold) begin
               convCnt_d = convCycles;
               convStart_d = 1'b1;
               state_d = monitor_adc_pkg::ST_CONVERT;
            end
         end
         default: begin
            state_d = monitor_adc_pkg::ST_IDLE;
         end
      endcase
      // A host write in the same cycle overrides a hardware clear.
      if (regReq.wrEn) begin
         if (regReq.addr == monitor_adc_pkg::CTRL_ADDR) begin
            ctrl_d = regReq.wrData;
         end else if (regReq.addr == monitor_adc_pkg::DIS_ADDR) begin
            dis_d = regReq.wrData;
         end else if (regReq.addr == monitor_adc_pkg::MASK_ADDR) begin
            mask_d = regReq.wrData;
         end
      end
      rdData_d = rdData_q;
      if (regReq.rdEn) begin
         if (regReq.addr == monitor_adc_pkg::STAT_ADDR) begin
            rdData_d = status;
         end else if (regReq.addr == monitor_adc_pkg::FLAG_ADDR) begin
            rdData_d = flag_q;
         end else if (regReq.addr == monitor_adc_pkg::MASK_ADDR) begin
            rdData_d = mask_q;
         end else if (regReq.addr == monitor_adc_pkg::CTRL_ADDR) begin
            rdData_d = ctrl_q;
         end else if (regReq.addr == monitor_adc_pkg::DIS_ADDR) begin
            rdData_d = dis_q;
         end else if (regReq.addr >= monitor_adc_pkg::RB_FIRST_ADDR &&
                      regReq.addr <= monitor_adc_pkg::RB_LAST_ADDR) begin
            rdData_d = rbIdx[0] ? rb_q[rbIdx[3:1]][7:0]
                                : rb_q[rbIdx[3:1]][15:8];
         end else begin
            rdData_d = monitor_adc_pkg::UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinS1_q <= '0;
         pinS2_q <= '0;
         pinS3_q <= '0;
         pinF_q <= '0;
         ctrl_q <= monitor_adc_pkg::CTRL_RESET;
         dis_q <= monitor_adc_pkg::DIS_RESET;
         mask_q <= monitor_adc_pkg::MASK_RESET;
         flag_q <= 8'h00;
         statPrev_q <= 8'h00;
         rdData_q <= 8'h00;
         alertCnt_q <= '0;
         alertActive_q <= 1'b0;
         startup_q <= 1'b1;
         doneStat_q <= 1'b0;
         goodPin_q <= 1'b0;
         swEn_q <= 1'b0;
         state_q <= monitor_adc_pkg::ST_IDLE;
         ch_q <= 3'h0;
         cycleMask_q <= '0;
         convCnt_q <= '0;
         convStart_q <= 1'b0;
         for (int i = 0; i < N; i++) begin
            rb_q[i] <= 16'h0000;
         end
      end else begin
         pinS1_q <= pins;
         pinS2_q <= pinS1_q;
         pinS3_q <= pinS2_q;
         pinF_q <= pinF_d;
         ctrl_q <= ctrl_d;
         dis_q <= dis_d;
         mask_q <= mask_d;
         flag_q <= flag_d;
         statPrev_q <= status;
         rdData_q <= rdData_d;
         alertCnt_q <= alertCnt_d;
         alertActive_q <= (alertCnt_d != '0);
         startup_q <= 1'b0;
         doneStat_q <= doneStat_d;
         goodPin_q <= powerGood;
         swEn_q <= pinF_q.vbusBelowOv & pinF_q.poorSourcePassed;
         state_q <= state_d;
         ch_q <= ch_d;
         cycleMask_q <= cycleMask_d;
         convCnt_q <= convCnt_d;
         convStart_q <= convStart_d;
         rb_q <= rb_d;
      end
   end

   assign regRdData = rdData_q;
   assign convStart = convStart_q;
   assign convChannel = ch_q;
   assign alertPin_n = ~alertActive_q;
   assign powerGoodPin_n = ~goodPin_q;
   assign switchingEnable = swEn_q;

endmodule

`default_nettype wire

/* File: verification/monitor_adc_chk.sv */
/* Port-level assertions for the monitoring converter and alert block.
   Bound from the testbench top; assumes conversions of 4 or more cycles. */
`timescale 1ns/1ns
`default_nettype none
module monitor_adc_chk #(
   parameter int ALERT_CYCLES = 16,
   parameter int CONV_BASE_CYCLES = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire monitor_adc_pkg::regReq_type regReq,
   input wire logic [7:0] regRdData,
   input wire monitor_adc_pkg::chargerPins_type pins,
   input wire logic [15:0] convData,
   input wire logic convStart,
   input wire logic [2:0] convChannel,
   input wire logic alertPin_n,
   input wire logic powerGoodPin_n,
   input wire logic switchingEnable
);
   logic [15:0] lowCnt_q, lowCnt_d, upCnt_q, upCnt_d;
   logic goodAll;
   assign goodAll = pins.vbusAboveUvlo && pins.vbusBelowOv &&
                  pins.poorSourcePassed && pins.detectDone;
   always_comb begin
      lowCnt_d = alertPin_n ? 16'h0000 : lowCnt_q + 16'h0001;
      upCnt_d = (upCnt_q == 16'hffff) ? upCnt_q : upCnt_q + 16'h0001;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lowCnt_q <= 16'h0000;
         upCnt_q <= 16'h0000;
      end else begin
         lowCnt_q <= lowCnt_d;
         upCnt_q <= upCnt_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   alert_width_a: assert property ($rose(alertPin_n) |->
      lowCnt_q >= 16'(ALERT_CYCLES)) else $error("alert pulse too short");
   startup_alert_a: assert property (upCnt_q == 16'h0004 |->
      !alertPin_n) else $error("no alert pulse after power-up");
   good_off_a: assert property ((!goodAll)[*8] |=> powerGoodPin_n)
      else $error("power good shown without all conditions");
   good_on_a: assert property (goodAll[*8] |=> !powerGoodPin_n)
      else $error("power good missing");
   ovp_stop_a: assert property ((!pins.vbusBelowOv)[*8] |=>
      !switchingEnable) else $error("switching during over-voltage");
   mode_pause_a: assert property (pins.modeChangeBusy[*8] |=>
      !convStart) else $error("conversion during mode change");
   detect_wait_a: assert property ((pins.vbusAboveUvlo &&
      !pins.detectDone)[*8] |=> !convStart)
      else $error("conversion before detection done");
   conv_gap_a: assert property (convStart |=> (!convStart)[*3])
      else $error("conversion shorter than sample time");
   chan_range_a: assert property (convStart |-> convChannel != 3'h7)
      else $error("conversion of nonexistent channel");
   unmapped_rd_a: assert property (regReq.rdEn && regReq.addr == 8'h30
      |=> regRdData == 8'hff) else $error("unmapped read not all ones");
   cover property ($fell(alertPin_n));
   cover property (convStart && convChannel == 3'h6);
   cover property ($fell(powerGoodPin_n));
endmodule
`default_nettype wire

/* File: verification/host_alert_model.sv */
/* Host side watcher of the alert pin: counts pulses and their widths.
   Assumes the alert pin is sampled on the system clock. */
`timescale 1ns/1ns
`default_nettype none
module host_alert_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic alertPin_n,
   output logic [7:0] pulseCnt,
   output logic [15:0] lastWidth
);
   logic [15:0] width_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         width_q <= 16'h0000;
         pulseCnt <= 8'h00;
         lastWidth <= 16'h0000;
      end else if (!alertPin_n) begin
         width_q <= width_q + 16'h0001;
      end else if (width_q != 16'h0000) begin
         pulseCnt <= pulseCnt + 8'h01;
         lastWidth <= width_q;
         width_q <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

/* File: verification/monitor_adc_and_host_alert_ctrl_tb.sv */
/* Self-checking bench for the converter sequencer and alert logic.
   Uses shortened alert and conversion counts; host model watches alerts. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module monitor_adc_and_host_alert_ctrl_tb;
   localparam int AC = 16;
   localparam int CB = 4;
   localparam logic [7:0] CTL = monitor_adc_pkg::CTRL_ADDR;
   localparam logic [7:0] DIS = monitor_adc_pkg::DIS_ADDR;
   localparam logic [7:0] FLG = monitor_adc_pkg::FLAG_ADDR;
   localparam logic [7:0] STA = monitor_adc_pkg::STAT_ADDR;
   localparam logic [10:0] GOOD = 11'h7c0;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   monitor_adc_pkg::regReq_type regReq = '0;
   monitor_adc_pkg::chargerPins_type pins = '0;
   logic [15:0] convData = 16'h0000;
   logic [7:0] regRdData, rd, pulseCnt, p0;
   logic [7:0] dis = 8'h00;
   logic convStart, alertPin_n, powerGoodPin_n, switchingEnable;
   logic [2:0] convChannel;
   logic [15:0] lastWidth, hold;
   logic [15:0] expRb[7], old[7];
   int err_total = 0, n_checks = 0, cyc = 0, startCnt = 0, s0;
   int gap = 0, lastStart = 0;
   always #20 clk = ~clk;
   monitor_adc_and_host_alert_ctrl #(.ALERT_CYCLES(AC),
      .CONV_BASE_CYCLES(CB)) dut_u (.clk(clk), .sys_rst(sys_rst),
      .regReq(regReq), .regRdData(regRdData), .pins(pins),
      .convData(convData), .convStart(convStart),
      .convChannel(convChannel), .alertPin_n(alertPin_n),
      .powerGoodPin_n(powerGoodPin_n),
      .switchingEnable(switchingEnable));
   host_alert_model host_u (.clk(clk), .sys_rst(sys_rst),
      .alertPin_n(alertPin_n), .pulseCnt(pulseCnt), .lastWidth(lastWidth));
   always @(negedge clk) begin
      if (convStart === 1'b1) begin
         `CHK(dis[convChannel + 3'h1], 1'b0)
         convData = 16'($urandom);
         expRb[convChannel] = convData;
         startCnt++;
         gap = cyc - lastStart;
         lastStart = cyc;
      end
   end
   task automatic end_sim;
      if (err_total == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_sim;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regReq = '{1'b1, 1'b0, a, d};
      @(negedge clk);
      regReq = '0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(negedge clk);
      regReq = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      regReq = '0;
      rd = regRdData;
   endtask
   task automatic waitIdle;
      for (int i = 0; i < 300; i++) begin
         rdr(CTL);
         if (rd[7] === 1'b0) break;
      end
   endtask
   task automatic checkRb;
      for (int c = 0; c < 7; c++) begin
         rdr(8'h17 + 8'(2 * c));
         hold[15:8] = rd;
         rdr(8'h18 + 8'(2 * c));
         hold[7:0] = rd;
         `CHK(hold, expRb[c])
      end
   endtask
   function automatic int expGap(input logic [1:0] s);
      return CB * (8 >> s);
   endfunction
   task automatic shot(input logic [7:0] m, input logic [1:0] smp);
      wr(monitor_adc_pkg::MASK_ADDR, m);
      p0 = pulseCnt;
      wr(CTL, 8'h80 | {2'b00, smp, 4'h0});
      waitIdle;
      `CHK(rd[7], 1'b0)
      if (dis[2] == 1'b0) `CHK(gap, expGap(smp))
      rdr(STA);
      `CHK(rd[0], 1'b1)
      rdr(FLG);
      `CHK(rd[0], 1'b1)
      repeat (AC + 4) @(negedge clk);
      `CHK(pulseCnt, p0 + {7'h00, ~m[0]})
   endtask
   initial begin
      void'($urandom(12029));
      for (int c = 0; c < 7; c++) expRb[c] = 16'h0000;
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      repeat (30) @(negedge clk);
      `CHK(lastWidth, 16'(AC))
      rdr(CTL);
      `CHK(rd, 8'h30)
      rdr(DIS);
      `CHK(rd, 8'h00)
      rdr(8'h30);
      rdr(FLG);
      `CHK(rd[5], 1'b1)
      rdr(FLG);
      `CHK(rd[5], 1'b0)
      pins = GOOD;
      repeat (40) @(negedge clk);
      `CHK(powerGoodPin_n, 1'b0)
      rdr(STA);
      `CHK(rd[1], 1'b1)
      for (int k = 0; k < 5; k++) begin
         dis = (k == 0) ? 8'h00 : (k == 3) ? 8'hfc : 8'($urandom) & 8'hf8;
         wr(DIS, dis);
         shot({7'h00, k == 4}, 2'(k));
         checkRb;
      end
      dis = 8'hfe;
      wr(DIS, dis);
      p0 = pulseCnt;
      wr(CTL, 8'hb0);
      rdr(CTL);
      `CHK(rd[7], 1'b0)
      wr(CTL, 8'hf0);
      rdr(CTL);
      `CHK(rd[7], 1'b1)
      `CHK(pulseCnt, p0)
      s0 = startCnt;
      dis = 8'h00;
      wr(DIS, dis);
      pins.modeChangeBusy = 1'b1;
      repeat (20) @(negedge clk);
      pins.modeChangeBusy = 1'b0;
      `CHK(startCnt > s0, 1'b1)
      s0 = startCnt;
      repeat (7) @(negedge clk);
      `CHK(startCnt > s0, 1'b1)
      `CHK(convChannel, 3'h0)
      rdr(STA);
      `CHK(rd[0], 1'b0)
      pins.detectDone = 1'b0;
      repeat (20) @(negedge clk);
      pins = GOOD;
      pins.vbusBelowOv = 1'b0;
      s0 = startCnt;
      repeat (30) @(negedge clk);
      `CHK(switchingEnable, 1'b0)
      `CHK(startCnt > s0, 1'b1)
      rdr(STA);
      `CHK(rd[2], 1'b1)
      pins = GOOD;
      repeat (20) @(negedge clk);
      `CHK(switchingEnable, 1'b1)
      wr(CTL, 8'hb0);
      waitIdle;
      `CHK(rd[7], 1'b0)
      checkRb;
      old = expRb;
      wr(CTL, 8'hf0);
      @(negedge clk);
      wr(CTL, 8'h70);
      s0 = startCnt;
      repeat (40) @(negedge clk);
      `CHK(startCnt, s0)
      expRb = old;
      checkRb;
      pins = '0;
      repeat (40) @(negedge clk);
      p0 = pulseCnt;
      wr(CTL, 8'hb0);
      rdr(CTL);
      `CHK(rd[7], 1'b0)
      repeat (30) @(negedge clk);
      `CHK(pulseCnt, p0)
      end_sim;
   end
endmodule
bind monitor_adc_and_host_alert_ctrl monitor_adc_chk #(
   .ALERT_CYCLES(ALERT_CYCLES), .CONV_BASE_CYCLES(CONV_BASE_CYCLES)) chk_u (
   .clk(clk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
   .pins(pins), .convData(convData), .convStart(convStart),
   .convChannel(convChannel), .alertPin_n(alertPin_n),
   .powerGoodPin_n(powerGoodPin_n), .switchingEnable(switchingEnable));
`default_nettype wire
